// [design/pdt_timer.sv]
`timescale 1ns/10ps
module pdt_timer
    import pdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic low_speed_osc,
    input wire logic high_speed_osc,
    input wire logic filter_clk_2048,
    input wire logic event_input_pin,
    input wire logic [7:0] reload_value_t0,
    input wire logic [7:0] reload_value_t1,
    input wire logic preset_load_t0,
    input wire logic preset_load_t1,
    input wire logic run_wr_t0,
    input wire logic run_wr_t1,
    input wire logic run_wdata_t0,
    input wire logic run_wdata_t1,
    input wire logic repeat_sel_t0,
    input wire logic repeat_sel_t1,
    input wire logic cascade_width_sel,
    input wire logic src_clk_sel_t0,
    input wire logic src_clk_sel_t1,
    input wire logic div_ratio_t0_lo,
    input wire logic div_ratio_t0_hi,
    input wire logic div_ratio_t1_lo,
    input wire logic div_ratio_t1_hi,
    input wire logic event_mode_sel,
    input wire logic edge_polarity_sel,
    input wire logic filter_func_sel,
    input wire logic toggle_chan_sel,
    output logic run_ctrl_t0,
    output logic run_ctrl_t1,
    output logic [7:0] count_readback_t0,
    output logic [7:0] count_readback_t1,
    output logic underflow_flag_t0,
    output logic underflow_flag_t1,
    output logic serial_clk_pulse,
    output logic underflow_toggle_out
);

    // Synchroniser stages for the oscillator, filter clock and event levels
    logic [2:0] low_sync_q;
    logic [2:0] high_sync_q;
    logic [2:0] fclk_sync_q;
    logic [1:0] ev_sync_q;

    // Noise filter state and the previous counted level
    logic filt_lvl_q;
    logic [1:0] filt_cnt_q;
    logic [1:0] filt_cnt_d;
    logic ev_prev_q;

    // Prescaler counts
    logic [5:0] psc0_q;
    logic [5:0] psc1_q;
    logic [5:0] psc0_d;
    logic [5:0] psc1_d;

    // Down counters, low byte and high byte
    logic [7:0] cnt0_q;
    logic [7:0] cnt1_q;
    logic [7:0] cnt0_d;
    logic [7:0] cnt1_d;

    // Run bits
    logic run0_q;
    logic run1_q;
    logic run0_d;
    logic run1_d;

    // Underflow pulse and toggle registers
    logic flag0_q;
    logic flag1_q;
    logic toggle_q;

    // Source edges are taken on the falling edge of the synchronised oscillator levels
    // Three stages leave one clean strobe per source period, so a slow edge cannot count twice
    wire low_tick = low_sync_q[2] & ~low_sync_q[1];
    wire high_tick = high_sync_q[2] & ~high_sync_q[1];
    wire fclk_fall = fclk_sync_q[2] & ~fclk_sync_q[1];
    wire ev_lvl = ev_sync_q[1];

    // Timer 1 selections are overridden by timer 0's in 16-bit mode
    wire src1_sel = cascade_width_sel ? src_clk_sel_t0 : src_clk_sel_t1;
    wire [1:0] ratio0 = {div_ratio_t0_hi, div_ratio_t0_lo};
    wire [1:0] ratio1 = cascade_width_sel ? ratio0 : {div_ratio_t1_hi, div_ratio_t1_lo};
    wire src0_tick = (src_clk_sel_t0 == PDT_SRC_HIGH) ? high_tick : low_tick;
    wire src1_tick = (src1_sel == PDT_SRC_HIGH) ? high_tick : low_tick;
    wire [5:0] last0 = pdt_psc_last(ratio0);
    wire [5:0] last1 = pdt_psc_last(ratio1);

    // Prescaler is fed only while running; timer 0 prescaler idles in event mode
    wire psc0_en = run0_q & ~event_mode_sel;
    wire psc1_en = run1_q;
    wire psc0_tick = psc0_en & src0_tick & (psc0_q == last0);
    wire psc1_tick = psc1_en & src1_tick & (psc1_q == last1);

    // Event level, optionally filtered, and its counting edge
    wire ev_use = filter_func_sel ? filt_lvl_q : ev_lvl;
    wire ev_tick = edge_polarity_sel ? (ev_use & ~ev_prev_q) : (~ev_use & ev_prev_q);

    // Count clocks of both counters
    wire tick0 = run0_q & (event_mode_sel ? ev_tick : psc0_tick);
    wire tick1 = ~cascade_width_sel & run1_q & psc1_tick;
    wire zero0 = (cnt0_q == PDT_BYTE_ZERO);
    wire zero1 = (cnt1_q == PDT_BYTE_ZERO);
    wire uf0_raw = tick0 & zero0;
    wire uf16 = cascade_width_sel & uf0_raw & zero1;
    wire uf0 = ~cascade_width_sel & uf0_raw;
    wire uf1 = cascade_width_sel ? uf16 : (tick1 & zero1);
    wire stop0 = (uf0 | uf16) & ~repeat_sel_t0;
    wire stop1 = uf1 & ~cascade_width_sel & ~repeat_sel_t1;
    wire load1 = cascade_width_sel ? preset_load_t0 : preset_load_t1;
    wire toggle_src = (cascade_width_sel | toggle_chan_sel) ? uf1 : uf0;

    // Prescaler counters restart from zero while stopped
    always_comb
    begin
        psc0_d = psc0_q;
        psc1_d = psc1_q;
        if (!psc0_en)
            psc0_d = PDT_PSC_RST;
        else if (src0_tick)
            psc0_d = (psc0_q == last0) ? PDT_PSC_RST : psc0_q + 6'h01;
        if (!psc1_en || cascade_width_sel)
            psc1_d = PDT_PSC_RST;
        else if (src1_tick)
            psc1_d = (psc1_q == last1) ? PDT_PSC_RST : psc1_q + 6'h01;
    end

    // Low byte: preset beats a count; in 16-bit mode it borrows through 0xFF while the high byte is nonzero
    always_comb
    begin
        cnt0_d = cnt0_q;
        if (preset_load_t0)
            cnt0_d = reload_value_t0;
        else if (tick0)
        begin
            if (!zero0)
                cnt0_d = cnt0_q - 8'h01;
            else if (cascade_width_sel && !zero1)
                cnt0_d = PDT_BYTE_MAX;
            else
                cnt0_d = reload_value_t0;
        end
    end

    // High byte: own clock in 8-bit mode, low-byte borrow in 16-bit mode
    always_comb
    begin
        cnt1_d = cnt1_q;
        if (load1)
            cnt1_d = reload_value_t1;
        else if (cascade_width_sel ? uf0_raw : tick1)
            cnt1_d = zero1 ? reload_value_t1 : cnt1_q - 8'h01;
    end

    // Run bits: a software write wins over the one-shot stop in the same cycle
    // so a restart issued as the one-shot ends is never lost
    always_comb
    begin
        run0_d = run0_q;
        if (run_wr_t0)
            run0_d = run_wdata_t0;
        else if (stop0)
            run0_d = 1'b0;
        run1_d = run1_q;
        if (cascade_width_sel)
            run1_d = 1'b0;
        else if (run_wr_t1)
            run1_d = run_wdata_t1;
        else if (stop1)
            run1_d = 1'b0;
    end

    // Filter counts sample-clock falls while the input differs from the held level
    // A glitch shorter than one sample period resets the count and never reaches the counter
    always_comb
    begin
        filt_cnt_d = PDT_FILT_RST;
        if (ev_lvl != filt_lvl_q)
            filt_cnt_d = fclk_fall ? filt_cnt_q + 2'h1 : filt_cnt_q;
    end

    // Synchronisers; first stage feeds only the second
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_sync_q <= 3'h0;
            high_sync_q <= 3'h0;
            fclk_sync_q <= 3'h0;
            ev_sync_q <= 2'h0;
        end
        else
        begin
            low_sync_q <= {low_sync_q[1:0], low_speed_osc};
            high_sync_q <= {high_sync_q[1:0], high_speed_osc};
            fclk_sync_q <= {fclk_sync_q[1:0], filter_clk_2048};
            ev_sync_q <= {ev_sync_q[0], event_input_pin};
        end
    end

    // Noise filter; when disabled it tracks the input so enabling it causes no spurious edge
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filt_lvl_q <= 1'b0;
            filt_cnt_q <= PDT_FILT_RST;
            ev_prev_q <= 1'b0;
        end
        else
        begin
            ev_prev_q <= ev_use;
            if (!filter_func_sel || (fclk_fall && filt_cnt_q + 2'h1 == PDT_FILT_EDGES))
            begin
                filt_lvl_q <= ev_lvl;
                filt_cnt_q <= PDT_FILT_RST;
            end
            else
                filt_cnt_q <= filt_cnt_d;
        end
    end

    // Counters, prescalers and run bits
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt0_q <= PDT_CNT_RST;
            cnt1_q <= PDT_CNT_RST;
            psc0_q <= PDT_PSC_RST;
            psc1_q <= PDT_PSC_RST;
            run0_q <= 1'b0;
            run1_q <= 1'b0;
        end
        else
        begin
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
            psc0_q <= psc0_d;
            psc1_q <= psc1_d;
            run0_q <= run0_d;
            run1_q <= run1_d;
        end
    end

    // Underflow pulses and toggle output, one cycle after the event
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flag0_q <= 1'b0;
            flag1_q <= 1'b0;
            toggle_q <= 1'b0;
        end
        else
        begin
            flag0_q <= uf0;
            flag1_q <= uf1;
            if (toggle_src)
                toggle_q <= ~toggle_q;
        end
    end

    assign run_ctrl_t0 = run0_q;
    assign run_ctrl_t1 = run1_q;
    assign count_readback_t0 = cnt0_q;
    assign count_readback_t1 = cnt1_q;
    assign underflow_flag_t0 = flag0_q;
    assign underflow_flag_t1 = flag1_q;
    assign serial_clk_pulse = flag1_q;
    assign underflow_toggle_out = toggle_q;

endmodule

// [design/pdt_pkg.sv]
package pdt_pkg;

    // Prescaler ratio codes
    localparam logic [1:0] PDT_DIV1 = 2'h0;
    localparam logic [1:0] PDT_DIV4 = 2'h1;
    localparam logic [1:0] PDT_DIV16 = 2'h2;
    localparam logic [1:0] PDT_DIV64 = 2'h3;

    // Terminal counts of the prescaler (ratio minus one)
    localparam logic [5:0] PDT_LAST_DIV1 = 6'h00;
    localparam logic [5:0] PDT_LAST_DIV4 = 6'h03;
    localparam logic [5:0] PDT_LAST_DIV16 = 6'h0F;
    localparam logic [5:0] PDT_LAST_DIV64 = 6'h3F;

    // Values after reset
    localparam logic [7:0] PDT_CNT_RST = 8'h00;
    localparam logic [5:0] PDT_PSC_RST = 6'h00;
    localparam logic [1:0] PDT_FILT_RST = 2'h0;

    // Count value that the low byte wraps to while the high byte borrows
    localparam logic [7:0] PDT_BYTE_MAX = 8'hFF;
    localparam logic [7:0] PDT_BYTE_ZERO = 8'h00;

    // Noise filter accepts a new level on this falling edge of its sample clock
    localparam logic [1:0] PDT_FILT_EDGES = 2'h2;

    // Source clock select codes
    localparam logic PDT_SRC_LOW = 1'b0;
    localparam logic PDT_SRC_HIGH = 1'b1;

    // Prescaler terminal count for a ratio code
    function automatic logic [5:0] pdt_psc_last(input logic [1:0] ratio);
        logic [5:0] r;
        r = PDT_LAST_DIV1;
        case (ratio)
            PDT_DIV1: r = PDT_LAST_DIV1;
            PDT_DIV4: r = PDT_LAST_DIV4;
            PDT_DIV16: r = PDT_LAST_DIV16;
            PDT_DIV64: r = PDT_LAST_DIV64;
            default: r = PDT_LAST_DIV1;
        endcase
        return r;
    endfunction

endpackage

// [dv/pdt_src_model.sv]
`timescale 1ns/10ps
module pdt_src_model
    import pdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    output logic low_speed_osc,
    output logic high_speed_osc,
    output logic filter_clk_2048
);
    logic [3:0] div_q;
    // Sources run and are settled from reset on, so no start meets a dead clock
    always_ff @(posedge mclk or negedge rst_n)
        if (!rst_n)
            div_q <= 4'h0;
        else
            div_q <= div_q + 4'h1;
    // Scaled rates keep the run short: high /4, low /8, filter sample /16
    assign high_speed_osc = div_q[1];
    assign low_speed_osc = div_q[2];
    assign filter_clk_2048 = div_q[3];
endmodule

// [dv/pdt_timer_monitor.sv]
`timescale 1ns/10ps
module pdt_timer_monitor
    import pdt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] reload_value_t0,
    input wire logic preset_load_t0,
    input wire logic run_wr_t0,
    input wire logic run_wdata_t0,
    input wire logic repeat_sel_t0,
    input wire logic cascade_width_sel,
    input wire logic toggle_chan_sel,
    input wire logic run_ctrl_t0,
    input wire logic run_ctrl_t1,
    input wire logic [7:0] count_readback_t0,
    input wire logic underflow_flag_t0,
    input wire logic underflow_flag_t1,
    input wire logic serial_clk_pulse,
    input wire logic underflow_toggle_out
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    preset_load_a:
        assert property (preset_load_t0 |=> count_readback_t0 == $past(reload_value_t0)) else $error("preset lost");
    run_write_a:
        assert property (run_wr_t0 |=> run_ctrl_t0 == $past(run_wdata_t0)) else $error("run write lost");
    // Ticks are only taken while the run bit is set
    stop_hold_a:
        assert property (!run_ctrl_t0 && !run_wr_t0 && !preset_load_t0 |=> $stable(count_readback_t0))
            else $error("count moved while stopped");
    under_reload_a:
        assert property (underflow_flag_t0 |-> count_readback_t0 == $past(reload_value_t0))
            else $error("no reload");
    serial_clk_a:
        assert property (serial_clk_pulse == underflow_flag_t1) else $error("serial clock off");
    // A run write in flight may legally override the mode
    cont_run_a:
        assert property (underflow_flag_t0 && $past(repeat_sel_t0) && !$past(run_wr_t0) && !$past(run_wr_t0, 2)
            |-> run_ctrl_t0) else $error("continuous stopped");
    oneshot_stop_a:
        assert property (underflow_flag_t0 && !$past(repeat_sel_t0) && !$past(run_wr_t0) |-> !run_ctrl_t0)
            else $error("one-shot kept running");
    run_hi_zero_a:
        assert property (cascade_width_sel && $past(cascade_width_sel) |-> !run_ctrl_t1) else $error("t1 run set");
    no_low_flag_a:
        assert property (cascade_width_sel && $past(cascade_width_sel) |-> !underflow_flag_t0)
            else $error("t0 flag in 16-bit");
    // Underflow followed by the toggle pin; 16-bit mode forces the combined one
    toggle_a:
        assert property ($changed(underflow_toggle_out) == (($past(cascade_width_sel) || $past(toggle_chan_sel))
            ? underflow_flag_t1 : underflow_flag_t0)) else $error("toggle mismatch");
    cover property (underflow_flag_t0 && repeat_sel_t0);
    cover property (underflow_flag_t0 && !run_ctrl_t0);
    cover property (underflow_flag_t1 && cascade_width_sel);
endmodule

// [dv/pdt_timer_tb.sv]
`timescale 1ns/10ps
module pdt_timer_tb;
    import pdt_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic low_speed_osc, high_speed_osc, filter_clk_2048;
    logic event_input_pin = 1'b1;
    logic [7:0] reload_value_t0 = 8'h00;
    logic [7:0] reload_value_t1 = 8'h00;
    logic preset_load_t0 = 1'b0, preset_load_t1 = 1'b0, run_wr_t0 = 1'b0, run_wr_t1 = 1'b0;
    logic run_wdata_t0 = 1'b0, run_wdata_t1 = 1'b0, repeat_sel_t0 = 1'b1, repeat_sel_t1 = 1'b1;
    logic cascade_width_sel = 1'b0, src_clk_sel_t0 = 1'b0, src_clk_sel_t1 = 1'b0, toggle_chan_sel = 1'b0;
    logic div_ratio_t0_lo = 1'b0, div_ratio_t0_hi = 1'b0, div_ratio_t1_lo = 1'b0, div_ratio_t1_hi = 1'b0;
    logic event_mode_sel = 1'b0, edge_polarity_sel = 1'b0, filter_func_sel = 1'b0;
    logic run_ctrl_t0, run_ctrl_t1, underflow_flag_t0, underflow_flag_t1, serial_clk_pulse, underflow_toggle_out;
    logic [7:0] count_readback_t0, count_readback_t1;
    int failures = 0;
    int compares = 0;
    int n;
    logic tog;
    // Clock and instances
    always #2.5 mclk = ~mclk;
    pdt_src_model u_pdt_src_model (.*);
    pdt_timer u_pdt_timer (.*);
    task automatic step(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic preset0;
        preset_load_t0 = 1'b1;
        step(1);
        preset_load_t0 = 1'b0;
    endtask
    task automatic run0(input logic v);
        run_wr_t0 = 1'b1;
        run_wdata_t0 = v;
        step(1);
        run_wr_t0 = 1'b0;
    endtask
    // Counts cycles up to the next one-cycle underflow pulse
    task automatic wait_flag(input logic hi, input int lim);
        n = 0;
        do
        begin
            step(1);
            n++;
        end
        while ((hi ? underflow_flag_t1 : underflow_flag_t0) !== 1'b1 && n < lim);
        if (n >= lim)
            chk(16'h0000, 16'h0001);
    endtask
    // Both levels held far beyond two filter sample periods unless a glitch is meant
    task automatic ev_pulse(input int w);
        event_input_pin = 1'b0;
        step(w);
        event_input_pin = 1'b1;
        step(60);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Tests need about 7k cycles; a hang is cut well after that
    initial
    begin
        step(20000);
        failures++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial
    begin
        step(10);
        rst_n = 1'b1;
        chk(count_readback_t0, 8'h00);
        reload_value_t0 = 8'h03;
        preset0();
        chk(count_readback_t0, 8'h03);
        run0(1'b1);
        chk(run_ctrl_t0, 1'b1);
        wait_flag(1'b0, 100);
        wait_flag(1'b0, 100);
        chk(n[15:0], 16'h0020);
        chk(count_readback_t0, 8'h03);
        step(12);
        run0(1'b0);
        step(40);
        chk(count_readback_t0, 8'h02);
        $display("Test continuous done");
        repeat_sel_t0 = 1'b0;
        run0(1'b1);
        wait_flag(1'b0, 100);
        chk(run_ctrl_t0, 1'b0);
        chk(n[15:0], 16'h0012);
        step(40);
        chk(count_readback_t0, 8'h03);
        run0(1'b1);
        wait_flag(1'b0, 100);
        chk({run_ctrl_t0, count_readback_t0}, 9'h003);
        $display("Test one-shot done");
        repeat_sel_t0 = 1'b1;
        reload_value_t0 = 8'h00;
        for (int k = 0; k < 8; k++)
        begin
            {div_ratio_t0_hi, div_ratio_t0_lo} = k[2:1];
            src_clk_sel_t0 = k[0];
            preset0();
            run0(1'b1);
            wait_flag(1'b0, 600);
            wait_flag(1'b0, 600);
            chk(n[15:0], 16'((k[0] ? 4 : 8) << (2 * k[2:1])));
            run0(1'b0);
        end
        $display("Test prescaler done");
        cascade_width_sel = 1'b1;
        {div_ratio_t0_hi, div_ratio_t0_lo} = 2'h0;
        {div_ratio_t1_hi, div_ratio_t1_lo} = 2'h3;
        {src_clk_sel_t0, src_clk_sel_t1} = 2'h1;
        reload_value_t0 = 8'h01;
        reload_value_t1 = 8'h01;
        preset0();
        chk({count_readback_t1, count_readback_t0}, 16'h0101);
        reload_value_t1 = 8'h77;
        {preset_load_t1, run_wr_t1, run_wdata_t1} = 3'h7;
        step(1);
        {preset_load_t1, run_wr_t1, reload_value_t1} = 10'h001;
        step(1);
        chk({run_ctrl_t1, count_readback_t1}, 9'h001);
        run0(1'b1);
        wait_flag(1'b1, 2200);
        wait_flag(1'b1, 2200);
        chk(n[15:0], 16'h0810);
        chk({count_readback_t1, count_readback_t0}, 16'h0101);
        run0(1'b0);
        cascade_width_sel = 1'b0;
        $display("Test cascade done");
        // Timer 1 on its own controls while timer 0 stays stopped
        toggle_chan_sel = 1'b1;
        {div_ratio_t1_hi, div_ratio_t1_lo} = 2'h1;
        reload_value_t1 = 8'h02;
        {preset_load_t1, run_wr_t1, run_wdata_t1} = 3'h7;
        step(1);
        {preset_load_t1, run_wr_t1} = 2'h0;
        wait_flag(1'b1, 200);
        tog = underflow_toggle_out;
        wait_flag(1'b1, 200);
        chk(n[15:0], 16'h0030);
        chk(underflow_toggle_out ^ tog, 1'b1);
        chk(count_readback_t0, 8'h01);
        {run_wr_t1, run_wdata_t1} = 2'h2;
        step(1);
        run_wr_t1 = 1'b0;
        chk(run_ctrl_t1, 1'b0);
        $display("Test timer 1 done");
        event_mode_sel = 1'b1;
        {div_ratio_t0_hi, div_ratio_t0_lo} = 2'h3;
        reload_value_t0 = 8'h0A;
        preset0();
        run0(1'b1);
        ev_pulse(60);
        ev_pulse(60);
        chk(count_readback_t0, 8'h08);
        edge_polarity_sel = 1'b1;
        ev_pulse(60);
        chk(count_readback_t0, 8'h07);
        filter_func_sel = 1'b1;
        ev_pulse(2);
        chk(count_readback_t0, 8'h07);
        ev_pulse(60);
        chk(count_readback_t0, 8'h06);
        cascade_width_sel = 1'b1;
        reload_value_t0 = 8'h00;
        reload_value_t1 = 8'h01;
        preset0();
        ev_pulse(60);
        chk({count_readback_t1, count_readback_t0}, 16'h00FF);
        $display("Test event done");
        end_of_test();
    end
endmodule
bind pdt_timer pdt_timer_monitor u_pdt_timer_monitor (.*);
